// file: logic/lcrs_pkg.sv
// Package with constants and types of the light curtain receiver supervisor.
package lcrs_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned RST_MIN_MS = 250;
  localparam int unsigned RST_MAX_MS = 2000;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned TEST_MS = 100;
  localparam int unsigned RST_MIN_CYC = (CLK_HZ / 1000) * RST_MIN_MS;
  localparam int unsigned RST_MAX_CYC = (CLK_HZ / 1000) * RST_MAX_MS;
  localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
  localparam int unsigned TEST_CYC = (CLK_HZ / 1000) * TEST_MS;
  localparam int CNT_W = 28;

  // ==========================================================================
  // Beams
  // ==========================================================================
  localparam int NUM_BEAMS = 8;
  localparam int TOP_BEAM = NUM_BEAMS - 1;
  localparam int BOTTOM_BEAM = 0;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h00C;
  localparam int CTRL_LATCH_BIT = 0;
  localparam int CTRL_TEST_BIT = 1;
  localparam logic CTRL_LATCH_RST = 1'b0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_OUT_BIT = 4;
  localparam int STAT_EMIT_BIT = 5;
  localparam int STAT_BEAM_LSB = 8;
  localparam int IRQ_W = 4;
  localparam int IRQ_LOCKOUT = 0;
  localparam int IRQ_TRIP = 1;
  localparam int IRQ_RST_OK = 2;
  localparam int IRQ_RST_BAD = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_SELFTEST,
    ST_SYNC,
    ST_WAIT_RESET,
    ST_RUN,
    ST_LATCHED,
    ST_TEST,
    ST_LOCKOUT
  } lcrs_state_t;

endpackage

// file: logic/lcrs_pulse_meter.sv
// Width qualifier for closures of the manual reset contact.
`timescale 1ns/1ps
module lcrs_pulse_meter
  import lcrs_pkg::*;
#(
  parameter logic [CNT_W-1:0] MIN_CYC = CNT_W'(RST_MIN_CYC),
  parameter logic [CNT_W-1:0] MAX_CYC = CNT_W'(RST_MAX_CYC)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic contact_closed,
  output logic accept,
  output logic reject
);

  logic [CNT_W-1:0] width_reg;
  logic closed_reg;

  // Counts the closure and saturates one past the longest valid width.
  always_ff @(posedge clk) begin
    if (rst) begin
      width_reg <= '0;
    end else if (!contact_closed) begin
      width_reg <= '0;
    end else if (width_reg <= MAX_CYC) begin
      width_reg <= width_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      closed_reg <= 1'b0;
    end else begin
      closed_reg <= contact_closed;
    end
  end

  // Judged on the opening edge; too short or too long is no reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      accept <= 1'b0;
      reject <= 1'b0;
    end else begin
      accept <= closed_reg && !contact_closed && width_reg >= MIN_CYC &&
                width_reg <= MAX_CYC;
      reject <= closed_reg && !contact_closed && width_reg > MAX_CYC;
    end
  end

endmodule

// file: logic/lcrs_blinker.sv
// Free-running square wave shared by every flashing indicator.
`timescale 1ns/1ps
module lcrs_blinker
  import lcrs_pkg::*;
#(
  parameter logic [CNT_W-1:0] HALF_CYC = CNT_W'(BLINK_HALF_CYC)
) (
  input wire logic clk,
  input wire logic rst,
  output logic blink
);

  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      blink <= 1'b0;
    end else if (cnt_reg >= HALF_CYC - CNT_W'(1)) begin
      cnt_reg <= '0;
      blink <= !blink;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

endmodule

// file: logic/lcrs_top.sv
// Supervisor of a safety light curtain receiver with an APB register port.
//
// Function
// - Trip mode: reset needed only after lockout.
// - Latch mode: reset after power-up, latch, lockout.
// - Closures longer than two seconds are ignored.
// - Power cycle restarts the power-up sequence.
// - Emitter lockout clears only by power cycle.
// - Latch waiting reset with all beams clear: alignment lamps blink together.
// - Top lamp lit while top beam clear, sync good.
// - Bottom lamp lit while bottom beam, sync good.
// - Green lit when clear with outputs on.
// - Test cycle: green blinks, red steady.
// - Red: blocked steady, lockout blinking, clear dark.
// - Emitter green: steady running, blinking on emitter fault.
// - Self-test fault stops scanning, outputs off.
// - Sync search precedes any beam evaluation.
// - Scanning classifies every beam blocked or clear.
// - Trip units enter run directly after sync.
// - Latch units need valid reset before run.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module lcrs_top
  import lcrs_pkg::*;
#(
  parameter logic [CNT_W-1:0] RST_MIN = CNT_W'(RST_MIN_CYC),
  parameter logic [CNT_W-1:0] RST_MAX = CNT_W'(RST_MAX_CYC),
  parameter logic [CNT_W-1:0] BLINK_HALF = CNT_W'(BLINK_HALF_CYC),
  parameter logic [CNT_W-1:0] TEST_LEN = CNT_W'(TEST_CYC)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_contact,
  input wire logic self_test_done,
  input wire logic self_test_fault,
  input wire logic run_fault,
  input wire logic emitter_fault,
  input wire logic sync_lock,
  input wire logic [NUM_BEAMS-1:0] beam_clear,
  input wire logic test_request,
  output logic [1:0] safety_switch_outputs,
  output logic align_top_led,
  output logic align_bottom_led,
  output logic clear_led,
  output logic blocked_led,
  output logic emitter_led,
  output logic irq
);

  // ==========================================================================
  // Shared helpers
  // ==========================================================================
  logic reset_ok;
  logic reset_bad;
  logic blink;

  lcrs_pulse_meter #(
    .MIN_CYC(RST_MIN),
    .MAX_CYC(RST_MAX)
  ) u_meter (
    .clk(clk),
    .rst(rst),
    .contact_closed(reset_contact),
    .accept(reset_ok),
    .reject(reset_bad)
  );

  lcrs_blinker #(
    .HALF_CYC(BLINK_HALF)
  ) u_blink (
    .clk(clk),
    .rst(rst),
    .blink(blink)
  );

  // ==========================================================================
  // Registers and declarations
  // ==========================================================================
  lcrs_state_t state_reg;
  logic latch_mode_reg;
  logic sw_test_reg;
  logic emitter_lock_reg;
  logic outputs_on_reg;
  logic [NUM_BEAMS-1:0] blocked_reg;
  logic [CNT_W-1:0] test_cnt_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_event;
  logic all_clear;
  logic scanning;
  logic fault;
  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic addr_hit;

  assign all_clear = &beam_clear;
  assign scanning = state_reg == ST_RUN || state_reg == ST_LATCHED ||
                    state_reg == ST_WAIT_RESET || state_reg == ST_TEST;
  assign fault = run_fault || emitter_fault || emitter_lock_reg;

  // ==========================================================================
  // Emitter lockout
  // ==========================================================================
  // Only a power-up reset clears it; the emitter has no reset input.
  always_ff @(posedge clk) begin
    if (rst) begin
      emitter_lock_reg <= 1'b0;
    end else if (emitter_fault) begin
      emitter_lock_reg <= 1'b1;
    end
  end

  // ==========================================================================
  // Supervisory state machine
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_SELFTEST;
    end else begin
      case (state_reg)
        ST_SELFTEST: begin
          if (self_test_fault || fault) begin
            state_reg <= ST_LOCKOUT;
          end else if (self_test_done) begin
            state_reg <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (fault) begin
            state_reg <= ST_LOCKOUT;
          end else if (sync_lock && latch_mode_reg) begin
            state_reg <= ST_WAIT_RESET;
          end else if (sync_lock) begin
            state_reg <= ST_RUN;
          end
        end
        ST_WAIT_RESET: begin
          if (fault) begin
            state_reg <= ST_LOCKOUT;
          end else if (!sync_lock) begin
            state_reg <= ST_SYNC;
          end else if (reset_ok && all_clear) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (fault) begin
            state_reg <= ST_LOCKOUT;
          end else if (!sync_lock) begin
            state_reg <= ST_SYNC;
          end else if (test_request || sw_test_reg) begin
            state_reg <= ST_TEST;
          end else if (!all_clear && latch_mode_reg) begin
            state_reg <= ST_LATCHED;
          end
        end
        ST_LATCHED: begin
          if (fault) begin
            state_reg <= ST_LOCKOUT;
          end else if (!sync_lock) begin
            state_reg <= ST_SYNC;
          end else if (all_clear) begin
            state_reg <= ST_WAIT_RESET;
          end
        end
        ST_TEST: begin
          if (fault) begin
            state_reg <= ST_LOCKOUT;
          end else if (test_cnt_reg >= TEST_LEN) begin
            state_reg <= ST_SELFTEST;
          end
        end
        ST_LOCKOUT: begin
          if (reset_ok && !emitter_lock_reg && !emitter_fault) begin
            state_reg <= ST_SELFTEST;
          end
        end
        default: begin
          state_reg <= ST_LOCKOUT;
        end
      endcase
    end
  end

  // Length of the remote or software test cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      test_cnt_reg <= '0;
    end else if (state_reg == ST_TEST) begin
      test_cnt_reg <= test_cnt_reg + CNT_W'(1);
    end else begin
      test_cnt_reg <= '0;
    end
  end

  // ==========================================================================
  // Beam scan
  // ==========================================================================
  // Beams are judged only while scanning; otherwise all count as blocked.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BEAMS; gi++) begin : g_beam
      always_ff @(posedge clk) begin
        if (rst) begin
          blocked_reg[gi] <= 1'b1;
        end else begin
          blocked_reg[gi] <= !(scanning && beam_clear[gi]);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Safety switching outputs
  // ==========================================================================
  // In trip mode a blocked screen turns the outputs off with no reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      outputs_on_reg <= 1'b0;
    end else begin
      outputs_on_reg <= state_reg == ST_RUN && all_clear && sync_lock &&
                        !fault && !test_request &&
                        !sw_test_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      safety_switch_outputs <= 2'h0;
    end else begin
      safety_switch_outputs <= {2{outputs_on_reg}};
    end
  end

  // ==========================================================================
  // Indicators
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      align_top_led <= 1'b0;
      align_bottom_led <= 1'b0;
    end else if (state_reg == ST_LOCKOUT) begin
      align_top_led <= blink;
      align_bottom_led <= blink;
    end else if (state_reg == ST_WAIT_RESET && all_clear) begin
      align_top_led <= blink;
      align_bottom_led <= blink;
    end else if (state_reg == ST_SELFTEST) begin
      align_top_led <= 1'b0;
      align_bottom_led <= 1'b0;
    end else begin
      align_top_led <= sync_lock && beam_clear[TOP_BEAM];
      align_bottom_led <= sync_lock && beam_clear[BOTTOM_BEAM];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clear_led <= 1'b0;
      blocked_led <= 1'b1;
    end else if (state_reg == ST_LOCKOUT) begin
      clear_led <= 1'b0;
      blocked_led <= blink;
    end else if (state_reg == ST_TEST) begin
      clear_led <= blink;
      blocked_led <= 1'b1;
    end else if (state_reg == ST_WAIT_RESET && all_clear) begin
      clear_led <= 1'b1;
      blocked_led <= 1'b0;
    end else begin
      clear_led <= outputs_on_reg;
      blocked_led <= !outputs_on_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      emitter_led <= 1'b1;
    end else if (emitter_lock_reg) begin
      emitter_led <= blink;
    end else begin
      emitter_led <= 1'b1;
    end
  end

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  always_comb begin
    irq_event = '0;
    irq_event[IRQ_LOCKOUT] = state_reg != ST_LOCKOUT && fault;
    irq_event[IRQ_TRIP] = outputs_on_reg && !(state_reg == ST_RUN &&
                          all_clear && sync_lock && !fault);
    irq_event[IRQ_RST_OK] = reset_ok;
    irq_event[IRQ_RST_BAD] = reset_bad;
  end

  // A new event in the cycle of a write-one clear keeps its bit set.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_reg <= '0;
    end else if (apb_wr && paddr == IRQ_STAT_OFS) begin
      irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ==========================================================================
  // APB slave
  // ==========================================================================
  // Every access takes one wait state; pready is high in the second cycle.
  assign apb_access = psel && penable && !pready;
  assign apb_wr = apb_access && pwrite && addr_hit;
  assign apb_rd = apb_access && !pwrite;
  assign addr_hit = paddr == CTRL_OFS || paddr == STATUS_OFS ||
                    paddr == IRQ_STAT_OFS || paddr == IRQ_MASK_OFS;

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access && !addr_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      latch_mode_reg <= CTRL_LATCH_RST;
    end else if (apb_wr && paddr == CTRL_OFS) begin
      latch_mode_reg <= pwdata[CTRL_LATCH_BIT];
    end
  end

  // The software test request is a one-shot; it clears once taken.
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_test_reg <= 1'b0;
    end else if (apb_wr && paddr == CTRL_OFS) begin
      sw_test_reg <= pwdata[CTRL_TEST_BIT];
    end else if (state_reg != ST_RUN) begin
      sw_test_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (apb_wr && paddr == IRQ_MASK_OFS) begin
      irq_mask_reg <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        CTRL_OFS: begin
          prdata[CTRL_LATCH_BIT] <= latch_mode_reg;
          prdata[CTRL_TEST_BIT] <= sw_test_reg;
        end
        STATUS_OFS: begin
          prdata[STAT_STATE_LSB +: 3] <= state_reg;
          prdata[STAT_OUT_BIT] <= outputs_on_reg;
          prdata[STAT_EMIT_BIT] <= emitter_lock_reg;
          prdata[STAT_BEAM_LSB +: NUM_BEAMS] <= blocked_reg;
        end
        IRQ_STAT_OFS: begin
          prdata[IRQ_W-1:0] <= irq_stat_reg;
        end
        IRQ_MASK_OFS: begin
          prdata[IRQ_W-1:0] <= irq_mask_reg;
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule

// file: sim/lcrs_top_properties.sv
// Concurrent checks on the ports of the receiver supervisor.
`timescale 1ns/1ps
module lcrs_top_properties
  import lcrs_pkg::*;
#(
  parameter logic [CNT_W-1:0] RST_MIN = CNT_W'(RST_MIN_CYC),
  parameter logic [CNT_W-1:0] RST_MAX = CNT_W'(RST_MAX_CYC),
  parameter logic [CNT_W-1:0] BLINK_HALF = CNT_W'(BLINK_HALF_CYC),
  parameter logic [CNT_W-1:0] TEST_LEN = CNT_W'(TEST_CYC)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic run_fault,
  input wire logic emitter_fault,
  input wire logic sync_lock,
  input wire logic [NUM_BEAMS-1:0] beam_clear,
  input wire logic [1:0] safety_switch_outputs,
  input wire logic clear_led,
  input wire logic blocked_led,
  input wire logic emitter_led
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_pair_equal: assert property (
    safety_switch_outputs[0] == safety_switch_outputs[1])
    else $error("safety output bits differ");
  a_ready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_out_needs_clear: assert property (safety_switch_outputs[0] |->
    $past(&beam_clear, 2) && $past(sync_lock, 2))
    else $error("outputs on without clear beams");
  a_clear_led_on: assert property (safety_switch_outputs[0] &&
    $past(safety_switch_outputs[0]) |-> clear_led && !blocked_led)
    else $error("indicators wrong with outputs on");
  a_fault_drops: assert property ($rose(run_fault) |->
    ##3 (safety_switch_outputs == 2'b00) [*4])
    else $error("outputs on after fault");
  a_emit_lock: assert property (emitter_fault |->
    ##3 safety_switch_outputs == 2'b00)
    else $error("outputs on after emitter fault");
  a_reset_values: assert property ($fell(rst) |-> blocked_led &&
    emitter_led && safety_switch_outputs == 2'b00)
    else $error("wrong values after reset");
endmodule

// file: sim/lcrs_far_side.sv
// Model of the operator reset switch facing the receiver.
`timescale 1ns/1ps
module lcrs_far_side (
  input wire logic clk,
  input wire logic press,
  input wire logic [7:0] press_len,
  output logic reset_contact,
  output logic idle
);
  logic [7:0] cnt_reg = 8'h00;
  initial reset_contact = 1'b0;
  // The contact stays closed for exactly press_len cycles, then opens.
  always @(posedge clk) begin
    if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
      if (cnt_reg == 8'h01) reset_contact <= 1'b0;
    end else if (press) begin
      cnt_reg <= press_len;
      reset_contact <= 1'b1;
    end
  end
  assign idle = (cnt_reg == 8'h00) && !reset_contact;
endmodule

// file: sim/tb_lcrs_top.sv
// Self-checking bench for the receiver supervisor.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin \
  failures++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_lcrs_top
  import lcrs_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  logic pready, pslverr, rd_err, reset_contact, idle, press = 1'b0;
  logic [7:0] press_len = 8'h00, beam_clear = 8'hFF;
  logic self_test_done = 1'b0, self_test_fault = 1'b0, run_fault = 1'b0;
  logic emitter_fault = 1'b0, sync_lock = 1'b0, test_request = 1'b0;
  logic [1:0] safety_switch_outputs;
  logic align_top_led, align_bottom_led, clear_led, blocked_led, emitter_led;
  logic irq;
  logic [4:0] leds;
  int failures = 0, n_compared = 0, hi[5], unis;
  always #4 clk = ~clk;
  assign leds = {emitter_led, blocked_led, clear_led, align_bottom_led,
                 align_top_led};
  lcrs_top #(.RST_MIN(28'h8), .RST_MAX(28'h28), .BLINK_HALF(28'h4),
    .TEST_LEN(28'h20)) lcrs_top_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_contact(reset_contact), .self_test_done(self_test_done),
    .self_test_fault(self_test_fault), .run_fault(run_fault),
    .emitter_fault(emitter_fault), .sync_lock(sync_lock),
    .beam_clear(beam_clear), .test_request(test_request),
    .safety_switch_outputs(safety_switch_outputs),
    .align_top_led(align_top_led), .align_bottom_led(align_bottom_led),
    .clear_led(clear_led), .blocked_led(blocked_led),
    .emitter_led(emitter_led), .irq(irq));
  lcrs_far_side lcrs_far_side_i (.clk(clk), .press(press),
    .press_len(press_len), .reset_contact(reset_contact), .idle(idle));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic fail_out(input string what);
    failures++;
    $display("wrong value %s exp done got timeout", what);
    tally_and_finish();
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) fail_out("pready");
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_st(input lcrs_state_t s);
    int k;
    for (k = 0; k < 100; k++) begin
      apb(1'b0, STATUS_OFS, 32'h0);
      if (rd_data[2:0] === s) break;
    end
    if (k == 100) fail_out(s.name());
  endtask
  task automatic push(input logic [7:0] len);
    int k;
    @(posedge clk);
    press <= 1'b1;
    press_len <= len;
    @(posedge clk);
    press <= 1'b0;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (idle) break;
    end
    repeat (4) @(posedge clk);
  endtask
  // Samples the lamps for 12 cycles to tell steady from blinking.
  task automatic watch();
    foreach (hi[i]) hi[i] = 0;
    unis = 0;
    repeat (12) begin
      @(posedge clk);
      #1;
      foreach (hi[i]) hi[i] += leds[i];
      if (align_top_led !== align_bottom_led) unis++;
    end
  endtask
  function automatic logic blinks(input int n);
    return n > 0 && n < 12;
  endfunction

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl", 32'h0, rd_data)
    apb(1'b0, IRQ_MASK_OFS, 32'h0);
    `CHK("mask", 32'h0, rd_data)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK("state", ST_SELFTEST, rd_data[2:0])
    `CHK("leds", 5'h18, leds)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped err", 1'b1, rd_err)
    `CHK("unmapped data", 32'h0, rd_data)
    $display("test reset done");
    self_test_done <= 1'b1;
    wait_st(ST_SYNC);
    repeat (20) @(posedge clk);
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK("no sync", {8'hFF, 5'h0, ST_SYNC}, rd_data[15:0])
    sync_lock <= 1'b1;
    wait_st(ST_RUN);
    repeat (4) @(posedge clk);
    `CHK("outputs", 2'b11, safety_switch_outputs)
    `CHK("run leds", 5'h17, leds)
    beam_clear <= 8'h7E;
    repeat (4) @(posedge clk);
    `CHK("blocked outputs", 2'b00, safety_switch_outputs)
    `CHK("blocked leds", 5'h18, leds)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK("beams", {8'h81, 5'h0, ST_RUN}, rd_data[15:0])
    beam_clear <= 8'hFF;
    repeat (4) @(posedge clk);
    `CHK("trip recover", 2'b11, safety_switch_outputs)
    $display("test trip done");
    apb(1'b1, CTRL_OFS, 32'h2);
    wait_st(ST_TEST);
    watch();
    `CHK("test green", 1'b1, blinks(hi[2]))
    `CHK("test red", 12, hi[3])
    wait_st(ST_RUN);
    test_request <= 1'b1;
    wait_st(ST_TEST);
    test_request <= 1'b0;
    `CHK("remote test", 2'b00, safety_switch_outputs)
    wait_st(ST_RUN);
    $display("test cycle done");
    apb(1'b1, IRQ_MASK_OFS, 32'h4);
    apb(1'b1, CTRL_OFS, 32'h1);
    beam_clear <= 8'hEF;
    wait_st(ST_LATCHED);
    beam_clear <= 8'hFF;
    wait_st(ST_WAIT_RESET);
    watch();
    `CHK("align blink", 1'b1, blinks(hi[0]))
    `CHK("unison", 0, unis)
    `CHK("wait green", 12, hi[2])
    `CHK("wait outputs", 2'b00, safety_switch_outputs)
    push(8'h04);
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK("short press", ST_WAIT_RESET, rd_data[2:0])
    push(8'h32);
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK("long press", ST_WAIT_RESET, rd_data[2:0])
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    `CHK("discard flag", 1'b1, rd_data[IRQ_RST_BAD])
    `CHK("masked irq", 1'b0, irq)
    push(8'h14);
    wait_st(ST_RUN);
    repeat (3) @(posedge clk);
    `CHK("latch run", 2'b11, safety_switch_outputs)
    `CHK("irq up", 1'b1, irq)
    apb(1'b1, IRQ_STAT_OFS, 32'hC);
    repeat (3) @(posedge clk);
    `CHK("irq down", 1'b0, irq)
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    `CHK("w1c", 2'b00, rd_data[3:2])
    $display("test latch done");
    run_fault <= 1'b1;
    wait_st(ST_LOCKOUT);
    watch();
    `CHK("lock red", 1'b1, blinks(hi[3]))
    `CHK("lock green", 0, hi[2])
    `CHK("lock outputs", 2'b00, safety_switch_outputs)
    run_fault <= 1'b0;
    push(8'h14);
    wait_st(ST_WAIT_RESET);
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    `CHK("lock flag", 1'b1, rd_data[IRQ_LOCKOUT])
    push(8'h14);
    wait_st(ST_RUN);
    $display("test lockout done");
    emitter_fault <= 1'b1;
    wait_st(ST_LOCKOUT);
    watch();
    `CHK("emitter blink", 1'b1, blinks(hi[4]))
    push(8'h14);
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK("emitter lock", {1'b1, 2'b0, ST_LOCKOUT}, rd_data[5:0])
    @(posedge clk);
    rst <= 1'b1;
    emitter_fault <= 1'b0;
    self_test_done <= 1'b0;
    self_test_fault <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("emitter steady", 1'b1, emitter_led)
    wait_st(ST_LOCKOUT);
    `CHK("fault outputs", 2'b00, safety_switch_outputs)
    $display("test power cycle done");
    tally_and_finish();
  end
endmodule

bind lcrs_top lcrs_top_properties #(.RST_MIN(RST_MIN), .RST_MAX(RST_MAX),
  .BLINK_HALF(BLINK_HALF), .TEST_LEN(TEST_LEN)) lcrs_top_properties_i (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .run_fault(run_fault), .emitter_fault(emitter_fault),
  .sync_lock(sync_lock), .beam_clear(beam_clear),
  .safety_switch_outputs(safety_switch_outputs), .clear_led(clear_led),
  .blocked_led(blocked_led), .emitter_led(emitter_led));
